/* File: pat_arbiter.sv */
/*
 * Port arbitration table for one egress port: APB register slave, the
 * software table, the loaded copy and the slot walker that offers the
 * egress port. Assumes an APB master on the same clock and an egress
 * port that pulses period_done_i when an arbitration period ends.
 * Software is trusted to program only legal port codes; other codes
 * are passed over by the walker rather than flagged, so a table full
 * of unusable codes simply leaves the grant invalid.
 */
// Added by the designer: the APB slave port.
`include "pat_consts.svh"

// Operation
// - Word0 holds slots 0-7, slot0 lowest nibble
// - Word1 holds slots 8-15, ascending nibbles
// - Word2 holds slots 16-23, ascending nibbles
// - Slots read/write, reset to zero
// - Each period offers port named in slot
// - Invalid port slot skipped without delay
// - Codes 0,2-5 valid; others reserved
// - Word3 holds slots 24-31, 32 total
// - Dirty flag set on write, clear on load
// - Table used only when select is table
module pat_arbiter
    import pat_pkg::*;
#(
    parameter logic [3:0] EGRESS_PORT_ID = 4'h0, // Own id, never a target
    parameter bit IS_UPSTREAM = 1'b1 // Downstream ports show no dirty flag
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire pat_apb_req_t apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic period_done_i,
    output pat_grant_t grant_o,
    output logic table_dirty_o
);

    localparam int TBL_W = `PAT_NUM_WORDS * 32;

    // The table is kept twice: software edits one copy while the walker
    // keeps offering from the loaded copy, so a half-written table never
    // reaches the ingress ports. The price is a second 128-bit store,
    // traded for a table that changes only at a known point.
    // Both copies clear at reset, so the loaded copy is all zeros until the first load.

    // Bus slave state
    pat_bus_state_t bus_ff; // Answer phase tracker
    pat_bus_state_t nxt_bus;
    logic [31:0] prdata_ff; // Read data to master
    logic [31:0] nxt_prdata;
    logic pready_ff; // Answer strobe
    logic nxt_pready;
    logic pslverr_ff; // Unmapped address answer
    logic nxt_pslverr;

    // Control and status
    logic [2:0] arb_service_select_ff; // Arbitration service in use
    logic [2:0] nxt_sel;
    logic table_load_ff; // One-cycle load pulse
    logic nxt_load;
    logic table_dirty_flag_ff; // Table written, not yet loaded
    logic nxt_dirty;

    // Loaded table and walker
    logic [TBL_W-1:0] active_ff; // Copy the arbiter uses
    logic [TBL_W-1:0] nxt_active;
    logic [`PAT_PTR_W-1:0] ptr_ff; // Next slot to examine
    logic [`PAT_PTR_W-1:0] nxt_ptr;
    pat_grant_t grant_ff; // Current offer
    pat_grant_t nxt_grant;

    // Decode helpers
    logic access; // Access phase, answer cycle included
    logic commit; // Edge at which the transfer completes
    logic hit_tbl; // Address hits a table word
    logic hit_ctrl;
    logic hit_stat;
    logic [1:0] tbl_idx;
    logic [31:0] mem_rd;
    logic [TBL_W-1:0] sw_table;
    logic tbl_wr;
    logic ctrl_wr; // Committed write to the control word
    logic sel_is_table; // Table-based service in use
    logic advance; // Offer may move at this edge

    // Walker search results
    // Valid only while the loaded copy holds a usable slot
    logic found;
    logic [`PAT_PTR_W-1:0] found_slot;
    logic [3:0] found_id;

    // Address decode, shared by read and write; only the exact word
    // offsets hit, so a misaligned address answers with an error
    always_comb begin
        hit_ctrl = (apb_i.paddr == `PAT_OFS_CTRL);
        hit_stat = (apb_i.paddr == `PAT_OFS_STATUS);
        hit_tbl = (apb_i.paddr == `PAT_OFS_WORD0) || (apb_i.paddr == `PAT_OFS_WORD1)
            || (apb_i.paddr == `PAT_OFS_WORD2) || (apb_i.paddr == `PAT_OFS_WORD3);
        tbl_idx = apb_i.paddr[3:2]; // Word index within the table
        access = apb_i.psel && apb_i.penable;
        commit = access && pready_ff;
        tbl_wr = commit && apb_i.pwrite && hit_tbl;
        ctrl_wr = commit && apb_i.pwrite && hit_ctrl;
        sel_is_table = (arb_service_select_ff == `PAT_SEL_TABLE);
        // A stalled egress port keeps its offer; an empty one takes one
        advance = !grant_ff.valid || period_done_i;
    end

    // Software copy; read data valid one cycle after address
    // Reads and writes share the word index; they never collide
    // because the bus carries one transfer at a time, and a write is
    // seen by a read that starts right after it completes
    pat_table_mem #(
        .NUM_WORDS(`PAT_NUM_WORDS)
    ) u_table_mem (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(tbl_wr),
        .wr_idx_i(tbl_idx),
        .wr_data_i(apb_i.pwdata),
        .rd_idx_i(tbl_idx),
        .rd_data_o(mem_rd),
        .table_o(sw_table)
    );

    // Bus answer: one wait state so the store's read data is ready
    // The store registers its read data, so the word addressed in the
    // setup cycle is only valid in the first access cycle. Answering
    // there would need a combinational read path through the store.
    // Writes take the same wait state so every transfer looks alike
    // and the master needs no knowledge of the address map.
    always_comb begin
        nxt_bus = bus_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        case (bus_ff)
            PAT_BUS_IDLE: begin
                if (access) begin
                    nxt_bus = PAT_BUS_ANSWER;
                    nxt_pready = 1'b1;
                    // Unmapped addresses answer with an error and change nothing
                    nxt_pslverr = !(hit_tbl || hit_ctrl || hit_stat);
                    nxt_prdata = 32'h0000_0000; // Unmapped and writes read zero
                    // Read data is captured here and shown with pready
                    if (!apb_i.pwrite) begin
                        if (hit_tbl) begin
                            nxt_prdata = mem_rd;
                        end else if (hit_ctrl) begin
                            nxt_prdata[`PAT_CTRL_SEL_HI:`PAT_CTRL_SEL_LO] =
                                arb_service_select_ff;
                        end else if (hit_stat) begin
                            nxt_prdata[`PAT_STAT_DIRTY_BIT] = table_dirty_flag_ff;
                        end
                    end
                end
            end
            PAT_BUS_ANSWER: begin
                // Back to idle even if the master holds the request, so a request
                // still held after its answer is answered again after one idle cycle
                nxt_bus = PAT_BUS_IDLE; // Transfer completes at this edge
            end
            default: begin
                nxt_bus = PAT_BUS_IDLE;
            end
        endcase
    end

    // Bus answer registers
    // Read data holds after the answer until the next transfer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_ff <= PAT_BUS_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            bus_ff <= nxt_bus;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    // Control, load command and dirty flag
    // The load bit is a strobe, not state: it reads back as zero and
    // fires once per write that sets it. A table write that lands in the
    // load cycle is not copied, so the flag must stay set for it.
    // Hazard: clearing after the set would hide that late write.
    always_comb begin
        nxt_sel = arb_service_select_ff;
        nxt_load = 1'b0;
        nxt_dirty = table_dirty_flag_ff;
        if (ctrl_wr) begin
            nxt_sel = apb_i.pwdata[`PAT_CTRL_SEL_HI:`PAT_CTRL_SEL_LO];
            nxt_load = apb_i.pwdata[`PAT_CTRL_LOAD_BIT]; // Self-clearing
        end
        // Clear on load first so a write in the same cycle keeps it set
        if (table_load_ff) begin
            nxt_dirty = 1'b0;
        end
        if (tbl_wr) begin
            nxt_dirty = 1'b1;
        end
        // Downstream ports never report a pending table
        if (!IS_UPSTREAM) begin
            nxt_dirty = 1'b0;
        end
    end

    // Control registers
    // Service select resets to no table use
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            arb_service_select_ff <= `PAT_SEL_RST;
            table_load_ff <= 1'b0;
            table_dirty_flag_ff <= 1'b0;
        end else begin
            arb_service_select_ff <= nxt_sel;
            table_load_ff <= nxt_load;
            table_dirty_flag_ff <= nxt_dirty;
        end
    end

    // First usable slot from the pointer, wrapping; whole search in one
    // cycle so invalid slots cost no arbitration time
    // Limitation: a 32-deep priority chain is the longest path of the
    // block. A pipelined search would shorten it but would then spend
    // a cycle on every skipped slot, which the arbiter must not do.
    // Slot n sits at bit 4n of the loaded copy.
    always_comb begin
        logic [`PAT_PTR_W-1:0] idx;
        logic [3:0] id;
        idx = '0;
        id = '0;
        found = 1'b0;
        found_slot = '0;
        found_id = '0;
        for (int i = 0; i < `PAT_NUM_SLOTS; i++) begin
            idx = ptr_ff + `PAT_PTR_W'(i); // Wraps past the last slot
            id = active_ff[{idx, 2'b00} +: `PAT_SLOT_W];
            // Codes 0 and 2..5 name ports, own id excluded
            if (!found && (id == `PAT_ID_PORT0 || (id >= `PAT_ID_PORT2
                && id <= `PAT_ID_PORT5)) && id != EGRESS_PORT_ID) begin
                found = 1'b1;
                found_slot = idx;
                found_id = id;
            end
        end
    end

    // Walker next state
    // A load drops the current offer for one cycle so the next offer
    // comes from slot 0 of the new table, never from the old pointer.
    // Leaving table service also drops the offer, but keeps the pointer.
    always_comb begin
        nxt_active = active_ff;
        nxt_ptr = ptr_ff;
        nxt_grant = grant_ff;
        if (table_load_ff) begin
            nxt_active = sw_table; // Newly loaded table takes effect
            nxt_ptr = '0;
            nxt_grant = '0; // Offer resumes next cycle
        end else if (!sel_is_table) begin
            nxt_grant = '0; // Table not consulted
        end else if (advance) begin
            // Next offer; no usable slot leaves the grant invalid
            nxt_grant.valid = found;
            nxt_grant.slot = found_slot;
            nxt_grant.port_onehot = '0;
            if (found) begin
                // Low three bits of a legal code are the port number
                nxt_grant.port_onehot[found_id[2:0]] = 1'b1;
                nxt_ptr = found_slot + `PAT_PTR_W'(1);
            end
        end
    end

    // Walker registers
    // Offer and pointer clear with the table, so reset offers nothing
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            active_ff <= '0;
            ptr_ff <= '0;
            grant_ff <= '0;
        end else begin
            active_ff <= nxt_active;
            ptr_ff <= nxt_ptr;
            grant_ff <= nxt_grant;
        end
    end

    // Outputs straight from flip-flops
    // No logic between these registers and the pins
    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign grant_o = grant_ff;
    assign table_dirty_o = table_dirty_flag_ff;

endmodule

/* File: pat_consts.svh */
/*
 * Offsets, field positions, reset values and codes of the port arbitration
 * table block. Assumes it is included by bare name from the package and the
 * design modules. It holds definitions only.
 */
`ifndef PAT_CONSTS_SVH
`define PAT_CONSTS_SVH

// Register byte offsets (APB, one aligned word each)
`define PAT_OFS_CTRL 12'h214
`define PAT_OFS_STATUS 12'h218
`define PAT_OFS_WORD0 12'h220
`define PAT_OFS_WORD1 12'h224
`define PAT_OFS_WORD2 12'h228
`define PAT_OFS_WORD3 12'h22C

// Address decode width and table geometry
`define PAT_ADDR_W 12
`define PAT_NUM_WORDS 4
`define PAT_NUM_SLOTS 32
`define PAT_SLOT_W 4
`define PAT_PTR_W 5
`define PAT_NUM_PORTS 6

// Reset values
`define PAT_WORD_RST 32'h0000_0000
`define PAT_SEL_RST 3'h0

// Control register fields
`define PAT_CTRL_LOAD_BIT 16
`define PAT_CTRL_SEL_LO 17
`define PAT_CTRL_SEL_HI 19

// Status register fields
`define PAT_STAT_DIRTY_BIT 16

// Service select value that makes the arbiter use the table
`define PAT_SEL_TABLE 3'h4

// Slot codes
`define PAT_ID_PORT0 4'h0
`define PAT_ID_PORT2 4'h2
`define PAT_ID_PORT5 4'h5

`endif

/* File: pat_pkg.sv */
/*
 * Types shared by the port arbitration table design.
 * Assumes pat_consts.svh is on the include path.
 */
`include "pat_consts.svh"

package pat_pkg;

    // APB request as driven by the bus master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`PAT_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } pat_apb_req_t;

    // Grant presented to the ingress ports
    typedef struct packed {
        logic valid;
        logic [`PAT_PTR_W-1:0] slot;
        logic [`PAT_NUM_PORTS-1:0] port_onehot;
    } pat_grant_t;

    // Bus slave answer phase
    typedef enum logic {
        PAT_BUS_IDLE,
        PAT_BUS_ANSWER
    } pat_bus_state_t;

endpackage

/* File: pat_table_mem.sv */
/*
 * Table word store: software copy of the arbitration table.
 * Assumes one clock, synchronous active-low reset, one write per cycle.
 */
`include "pat_consts.svh"

module pat_table_mem
    import pat_pkg::*;
#(
    parameter int NUM_WORDS = `PAT_NUM_WORDS
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_idx_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [1:0] rd_idx_i,
    output logic [31:0] rd_data_o,
    output logic [NUM_WORDS*32-1:0] table_o
);

    logic [NUM_WORDS-1:0][31:0] word_ff; // Stored words
    logic [NUM_WORDS-1:0][31:0] nxt_word;
    logic [31:0] rd_ff; // Registered read data
    logic [31:0] nxt_rd;

    // Next values: write one word, read one word
    always_comb begin
        nxt_word = word_ff;
        if (wr_en_i) begin
            nxt_word[wr_idx_i] = wr_data_i;
        end
        nxt_rd = word_ff[rd_idx_i];
    end

    // Registers; every slot clears to zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            word_ff <= '0;
            rd_ff <= `PAT_WORD_RST;
        end else begin
            word_ff <= nxt_word;
            rd_ff <= nxt_rd;
        end
    end

    assign rd_data_o = rd_ff;
    assign table_o = word_ff;

endmodule

/* File: pat_arb_properties.sv */
/* Checker for the port arbitration table block, watching its ports only.
   Assumes one clock and the synchronous active-low reset of the block. */
`include "pat_consts.svh"

module pat_arb_chk
    import pat_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire pat_apb_req_t apb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic period_done_i,
    input wire pat_grant_t grant_o,
    input wire logic table_dirty_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Bus setup cycle and the one-wait-state answer
    sequence s_setup;
        apb_i.psel && !apb_i.penable;
    endsequence
    sequence s_answer;
        !pready_o ##1 pready_o;
    endsequence

    // Completed write to any address from word 0 to word 3, misaligned ones included
    logic tbl_wr;
    assign tbl_wr = apb_i.psel && apb_i.penable && apb_i.pwrite && pready_o
        && apb_i.paddr >= `PAT_OFS_WORD0 && apb_i.paddr <= `PAT_OFS_WORD3;

    a_one_wait_state: assert property (s_setup |=> s_answer)
        else $error("answer not after one wait state");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_err_read_zero: assert property (pslverr_o && !apb_i.pwrite |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_grant_onehot: assert property (grant_o.valid |-> $onehot(grant_o.port_onehot))
        else $error("grant names not exactly one port");
    a_no_reserved_port: assert property (grant_o.valid |-> !grant_o.port_onehot[1])
        else $error("reserved port granted");
    // Quiet bus for four cycles rules out a pending load or select change
    a_grant_holds: assert property (grant_o.valid && !period_done_i && !pready_o
        && !$past(pready_o) && !$past(pready_o, 2) && !$past(pready_o, 3) |=> $stable(grant_o))
        else $error("grant moved without period end");
    a_dirty_on_write: assert property (tbl_wr |=> ##[0:1] table_dirty_o)
        else $error("dirty flag not set by table write");
endmodule

/* File: pat_egress_model.sv */
/* Egress port model: ends each arbitration period after a set dwell.
   Assumes the arbiter's clock; dwell 0 stalls the period indefinitely. */
module pat_egress_model
    import pat_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire pat_grant_t grant_i,
    input wire logic [3:0] dwell_i,
    output logic period_done_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt_ff; // Cycles spent in the current period

    // One-cycle end pulse, never two in a row
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !grant_i.valid) begin
            cnt_ff <= 4'h0;
            period_done_o <= 1'b0;
        end else if (dwell_i != 4'h0 && cnt_ff >= dwell_i - 4'h1 && !period_done_o) begin
            cnt_ff <= 4'h0;
            period_done_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + {3'h0, !period_done_o};
            period_done_o <= 1'b0;
        end
    end
endmodule

/* File: pat_arbiter_tb.sv */
/* Self-checking bench: APB tasks, table read-back, grant walk and reload.
   Assumes the package, the checker and the egress model compile first. */
module pat_arbiter_tb
    import pat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    pat_apb_req_t apb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, done, dirty;
    pat_grant_t grant;
    logic [3:0] dwell = 4'h0; // Start with a stalled egress port
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int cmp_count = 0;
    // Expected grants {valid, slot, onehot}: code 3 is own id, others reserved
    logic [31:0] exp_q [5] = '{32'h0000_0910, 32'h0000_0960, 32'h0000_0981,
        32'h0000_0804, 32'h0000_0910};

    // Own id 3 so that an own-id slot is seen being skipped
    pat_arbiter #(.EGRESS_PORT_ID(4'h3), .IS_UPSTREAM(1'b1)) pat_arbiter_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .period_done_i(done), .grant_o(grant),
        .table_dirty_o(dirty));
    pat_egress_model pat_egress_model_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .grant_i(grant), .dwell_i(dwell), .period_done_o(done));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer; request held until ready is sampled high
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        // A missing answer ends the run
        if (i >= 20) begin
            n_fail++;
            report_and_stop();
        end
        apb <= '0;
        @(posedge ref_clk_i);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    function automatic logic [31:0] gword();
        return {20'h0, grant.valid, grant.slot, grant.port_onehot};
    endfunction

    // Bounded wait for the grant to move
    task automatic wait_change();
        pat_grant_t prev;
        int i = 0;
        prev = grant;
        while (grant === prev && i < 40) begin
            @(posedge ref_clk_i);
            i++;
        end
        if (i >= 40) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int w = 0; w < 4; w++) rd_chk(12'h220 + 12'(4 * w), 32'h0);
        rd_chk(12'h218, 32'h0);
        // Slots 0..7 = 2,1,3,F,4,5,0,6; all later slots reserved
        apb_xfer(1'b1, 12'h220, 32'h6054_F312);
        for (int w = 1; w < 4; w++) apb_xfer(1'b1, 12'h220 + 12'(4 * w), 32'hEEEE_EEE1);
        rd_chk(12'h220, 32'h6054_F312);
        for (int w = 1; w < 4; w++) rd_chk(12'h220 + 12'(4 * w), 32'hEEEE_EEE1);
        rd_chk(12'h218, 32'h0001_0000);
        check({31'h0, dirty}, 32'h1);
        // Unmapped read answers with error and zero
        rd_chk(12'h300, 32'h0);
        check({31'h0, err}, 32'h1);
        // Select table service and load
        apb_xfer(1'b1, 12'h214, 32'h0009_0000);
        wait_change();
        check(gword(), 32'h0000_0804);
        repeat (8) @(posedge ref_clk_i);
        check(gword(), 32'h0000_0804);
        rd_chk(12'h218, 32'h0);
        dwell <= 4'h3;
        for (int k = 0; k < 5; k++) begin
            wait_change();
            check(gword(), exp_q[k]);
        end
        // Leaving table service clears the grant
        dwell <= 4'h0;
        apb_xfer(1'b1, 12'h214, 32'h0000_0000);
        wait_change();
        check(gword(), 32'h0);
        // Legal codes only, own id 3 left out; reload restarts at slot 0
        for (int w = 0; w < 4; w++) apb_xfer(1'b1, 12'h220 + 12'(4 * w), 32'h5420_5402);
        apb_xfer(1'b1, 12'h214, 32'h0009_0000);
        wait_change();
        check(gword(), 32'h0000_0804);
        report_and_stop();
    end
endmodule

bind pat_arbiter pat_arb_chk pat_arb_chk_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .apb_i(apb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .period_done_i(period_done_i), .grant_o(grant_o), .table_dirty_o(table_dirty_o));
